//--- jtap_port.sv
/*
 * test access port controller: tap state machine, instruction register,
 * idcode/bypass/control data registers, return clock and strap capture.
 * assumes MCLK is far faster than the probe clock (40 MHz vs 5 MHz) so
 * each probe clock edge is seen after synchronisation; all probe pins,
 * including the probe reset, are asynchronous and pass two flip-flops.
 */
`timescale 1ns/1ps

// Summary of operation
// - low test reset initialises the controller after two-flop synchronisation to MCLK, independent of test clock.
// - serial output changes only on falling test clock edges.
// - serial input is sampled on rising test clock edges in the two shift states.
// - mode select is sampled on rising edges and steps the state machine.
// - apart from test reset and strap capture, all test logic and control accesses are paced by the test clock.
// - controller-select strap is captured when test reset deasserts.
// - return clock output, shared pin; disabled while single-wire use is chosen.
module jtap_port
  import jtap_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic TEST_RESET_N,
  input wire logic TEST_CLK,
  input wire logic TEST_MODE,
  input wire logic TEST_DIN,
  input wire logic CTRL_SELECT,
  input wire logic SINGLE_WIRE_EN,
  output logic TEST_DOUT,
  output logic TEST_DOUT_OE,
  output logic RETURN_TEST_CLOCK,
  output logic RETURN_TEST_CLOCK_OE,
  output logic DEBUG_SELECTED,
  output jtap_ctl_t CTRL_WRITE
);

  jtap_pins_t pins_raw;
  jtap_pins_t pins;
  jtap_state_t state_ff, nxt_state;
  logic tck_d_ff, nxt_tck_d;
  logic rst_d_ff, nxt_rst_d;
  logic [JTAP_IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
  logic [JTAP_DR_W-1:0] dr_sh_ff, nxt_dr_sh;
  logic [JTAP_CTL_W-1:0] ctl_ff, nxt_ctl;
  logic strobe_ff, nxt_strobe;
  logic sel_ff, nxt_sel;
  logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;
  logic ret_clk_ff, nxt_ret_clk, ret_clk_oe_ff, nxt_ret_clk_oe;
  logic rise, fall, tap_rst, rst_rise;

  assign pins_raw = '{tck: TEST_CLK, tms: TEST_MODE, tdi: TEST_DIN,
                      trst_n: TEST_RESET_N, sel: CTRL_SELECT};

  jtap_sync jtap_sync_i (
    .clk(MCLK),
    .rst_n(RESETN),
    .din(pins_raw),
    .dout(pins)
  );

  // edges of the probe clock, seen from MCLK
  assign rise = pins.tck & ~tck_d_ff;
  assign fall = ~pins.tck & tck_d_ff;
  assign tap_rst = ~pins.trst_n;
  assign rst_rise = pins.trst_n & ~rst_d_ff;

  // tap state machine, stepped by mode select at rising edges
  always_comb begin
    nxt_state = state_ff;
    if (tap_rst) begin
      nxt_state = JTAP_TLR;
    end else if (rise) begin
      unique case (state_ff)
        JTAP_TLR: nxt_state = pins.tms ? JTAP_TLR : JTAP_RTI;
        JTAP_RTI: nxt_state = pins.tms ? JTAP_SEL_DR : JTAP_RTI;
        JTAP_SEL_DR: nxt_state = pins.tms ? JTAP_SEL_IR : JTAP_CAP_DR;
        JTAP_CAP_DR: nxt_state = pins.tms ? JTAP_EX1_DR : JTAP_SH_DR;
        JTAP_SH_DR: nxt_state = pins.tms ? JTAP_EX1_DR : JTAP_SH_DR;
        JTAP_EX1_DR: nxt_state = pins.tms ? JTAP_UPD_DR : JTAP_PA_DR;
        JTAP_PA_DR: nxt_state = pins.tms ? JTAP_EX2_DR : JTAP_PA_DR;
        JTAP_EX2_DR: nxt_state = pins.tms ? JTAP_UPD_DR : JTAP_SH_DR;
        JTAP_UPD_DR: nxt_state = pins.tms ? JTAP_SEL_DR : JTAP_RTI;
        JTAP_SEL_IR: nxt_state = pins.tms ? JTAP_TLR : JTAP_CAP_IR;
        JTAP_CAP_IR: nxt_state = pins.tms ? JTAP_EX1_IR : JTAP_SH_IR;
        JTAP_SH_IR: nxt_state = pins.tms ? JTAP_EX1_IR : JTAP_SH_IR;
        JTAP_EX1_IR: nxt_state = pins.tms ? JTAP_UPD_IR : JTAP_PA_IR;
        JTAP_PA_IR: nxt_state = pins.tms ? JTAP_EX2_IR : JTAP_PA_IR;
        JTAP_EX2_IR: nxt_state = pins.tms ? JTAP_UPD_IR : JTAP_SH_IR;
        JTAP_UPD_IR: nxt_state = pins.tms ? JTAP_SEL_DR : JTAP_RTI;
      endcase
    end
  end

  // instruction and data shift paths, moved at rising edges only; test reset also reloads the instruction register
  always_comb begin
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_dr_sh = dr_sh_ff;
    nxt_ctl = ctl_ff;
    nxt_strobe = 1'b0;
    if (tap_rst) begin
      nxt_ir = JTAP_IR_RESET;
    end else if (rise) begin
      unique case (state_ff)
        JTAP_TLR: nxt_ir = JTAP_IR_RESET;
        JTAP_CAP_IR: nxt_ir_sh = {{(JTAP_IR_W-2){1'b0}}, JTAP_IR_CAPTURE};
        JTAP_SH_IR: nxt_ir_sh = {pins.tdi, ir_sh_ff[JTAP_IR_W-1:1]};
        JTAP_UPD_IR: nxt_ir = ir_sh_ff;
        JTAP_CAP_DR: begin
          if (ir_ff == JTAP_IR_IDCODE) begin
            nxt_dr_sh = JTAP_IDCODE_VAL;
          end else if (ir_ff == JTAP_IR_CTRL) begin
            nxt_dr_sh = {{(JTAP_DR_W-JTAP_CTL_W){1'b0}}, ctl_ff};
          end else begin
            nxt_dr_sh = '0;
          end
        end
        JTAP_SH_DR: begin
          if (ir_ff == JTAP_IR_IDCODE) begin
            nxt_dr_sh = {pins.tdi, dr_sh_ff[JTAP_DR_W-1:1]};
          end else if (ir_ff == JTAP_IR_CTRL) begin
            nxt_dr_sh = {{(JTAP_DR_W-JTAP_CTL_W){1'b0}}, pins.tdi,
                         dr_sh_ff[JTAP_CTL_W-1:1]};
          end else begin
            nxt_dr_sh = {{(JTAP_DR_W-1){1'b0}}, pins.tdi}; // bypass bit
          end
        end
        JTAP_UPD_DR: begin
          // control write lands only in the debugger-facing controller
          if (ir_ff == JTAP_IR_CTRL && sel_ff) begin
            nxt_ctl = dr_sh_ff[JTAP_CTL_W-1:0];
            nxt_strobe = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // serial output: picked at falling edges so the probe samples it stable
  always_comb begin
    nxt_tdo = tdo_ff;
    nxt_tdo_oe = tdo_oe_ff;
    if (tap_rst) begin
      nxt_tdo_oe = 1'b0;
    end else if (fall) begin
      nxt_tdo_oe = (state_ff == JTAP_SH_DR) || (state_ff == JTAP_SH_IR);
      nxt_tdo = (state_ff == JTAP_SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
    end
  end

  // strap capture at test reset release; return clock follows sampled clock
  always_comb begin
    nxt_sel = sel_ff;
    if (rst_rise) begin
      nxt_sel = pins.sel;
    end
    nxt_tck_d = pins.tck;
    nxt_rst_d = pins.trst_n;
    // return clock echoes the synchronised clock, pacing an adaptive probe
    nxt_ret_clk_oe = ~SINGLE_WIRE_EN;
    nxt_ret_clk = pins.tck & ~SINGLE_WIRE_EN;
  end

  // registers; reset of the whole block via RESETN
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= JTAP_TLR;
      tck_d_ff <= 1'b0;
      rst_d_ff <= 1'b0;
      ir_sh_ff <= '0;
      ir_ff <= JTAP_IR_RESET;
      dr_sh_ff <= '0;
      ctl_ff <= JTAP_CTL_RESET;
      strobe_ff <= 1'b0;
      sel_ff <= 1'b1;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
      ret_clk_ff <= 1'b0;
      ret_clk_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tck_d_ff <= nxt_tck_d;
      rst_d_ff <= nxt_rst_d;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      dr_sh_ff <= nxt_dr_sh;
      ctl_ff <= nxt_ctl;
      strobe_ff <= nxt_strobe;
      sel_ff <= nxt_sel;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
      ret_clk_ff <= nxt_ret_clk;
      ret_clk_oe_ff <= nxt_ret_clk_oe;
    end
  end

  assign TEST_DOUT = tdo_ff;
  assign TEST_DOUT_OE = tdo_oe_ff;
  assign RETURN_TEST_CLOCK = ret_clk_ff;
  assign RETURN_TEST_CLOCK_OE = ret_clk_oe_ff;
  assign DEBUG_SELECTED = sel_ff;
  assign CTRL_WRITE = '{strobe: strobe_ff, data: ctl_ff};

  // helper: consecutive rising edges with mode high, saturating so it never wraps
  logic [2:0] ones_cnt_ff, nxt_ones_cnt;
  always_comb begin
    nxt_ones_cnt = ones_cnt_ff;
    if (tap_rst || (rise && !pins.tms)) begin
      nxt_ones_cnt = 3'h0;
    end else if (rise && ones_cnt_ff != 3'h7) begin
      nxt_ones_cnt = ones_cnt_ff + 3'h1;
    end
  end

  // helper register
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ones_cnt_ff <= 3'h0;
    end else begin
      ones_cnt_ff <= nxt_ones_cnt;
    end
  end

  a_trst_forces_tlr: assert property (@(posedge MCLK) disable iff (!RESETN)
    tap_rst |=> state_ff == JTAP_TLR) else $error("test reset did not force reset state");

  a_dout_on_fall: assert property (@(posedge MCLK) disable iff (!RESETN)
    !fall |=> $stable(TEST_DOUT)) else $error("serial output moved off a falling edge");

  a_shift_takes_din: assert property (@(posedge MCLK) disable iff (!RESETN)
    (rise && !tap_rst && state_ff == JTAP_SH_IR) |=> ir_sh_ff[JTAP_IR_W-1] == $past(pins.tdi))
    else $error("instruction shift lost the input bit");

  a_state_on_rise: assert property (@(posedge MCLK) disable iff (!RESETN)
    (!rise && !tap_rst) |=> $stable(state_ff)) else $error("state moved without a clock edge");

  a_ctl_on_update: assert property (@(posedge MCLK) disable iff (!RESETN)
    !(rise && state_ff == JTAP_UPD_DR) |=> !strobe_ff) else $error("control write off update");

  a_strap_at_release: assert property (@(posedge MCLK) disable iff (!RESETN)
    rst_rise |=> DEBUG_SELECTED == $past(pins.sel)) else $error("strap not captured");

  a_ret_clk_shared: assert property (@(posedge MCLK) disable iff (!RESETN)
    SINGLE_WIRE_EN ##1 SINGLE_WIRE_EN |-> !RETURN_TEST_CLOCK_OE && !RETURN_TEST_CLOCK)
    else $error("return clock driven while single-wire active");

  a_five_ones_tlr: assert property (@(posedge MCLK) disable iff (!RESETN)
    ones_cnt_ff >= 3'(JTAP_TLR_ONES) |-> state_ff == JTAP_TLR)
    else $error("five ones did not reach reset");

endmodule

//--- jtap_pkg.sv
/*
 * package for the test access port: tap state encoding, instruction codes,
 * register widths and the packed carriers for pins and debug access.
 * assumes nothing of its surroundings.
 */
package jtap_pkg;

  localparam int JTAP_IR_W = 4;
  localparam int JTAP_DR_W = 32;
  localparam int JTAP_CTL_W = 8;
  localparam int JTAP_TLR_ONES = 5;

  // instruction codes, bypass is all ones
  localparam logic [JTAP_IR_W-1:0] JTAP_IR_IDCODE = 4'h1;
  localparam logic [JTAP_IR_W-1:0] JTAP_IR_CTRL = 4'h8;
  localparam logic [JTAP_IR_W-1:0] JTAP_IR_BYPASS = 4'hf;
  localparam logic [JTAP_IR_W-1:0] JTAP_IR_RESET = JTAP_IR_IDCODE;
  localparam logic [1:0] JTAP_IR_CAPTURE = 2'h1;

  // identification value, arbitrary
  localparam logic [JTAP_DR_W-1:0] JTAP_IDCODE_VAL = 32'h1234_5671;
  localparam logic [JTAP_CTL_W-1:0] JTAP_CTL_RESET = 8'h00;

  // tap states, gray-coded along the scan paths
  typedef enum logic [3:0] {
    JTAP_TLR = 4'h0,
    JTAP_RTI = 4'h1,
    JTAP_SEL_DR = 4'h3,
    JTAP_CAP_DR = 4'h2,
    JTAP_SH_DR = 4'h6,
    JTAP_EX1_DR = 4'h7,
    JTAP_PA_DR = 4'h5,
    JTAP_EX2_DR = 4'h4,
    JTAP_UPD_DR = 4'hc,
    JTAP_SEL_IR = 4'hd,
    JTAP_CAP_IR = 4'hf,
    JTAP_SH_IR = 4'he,
    JTAP_EX1_IR = 4'ha,
    JTAP_PA_IR = 4'hb,
    JTAP_EX2_IR = 4'h9,
    JTAP_UPD_IR = 4'h8
  } jtap_state_t;

  // probe-side pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic sel;
  } jtap_pins_t;

  // control word written through the port
  typedef struct packed {
    logic strobe;
    logic [JTAP_CTL_W-1:0] data;
  } jtap_ctl_t;

endpackage

//--- jtap_sync.sv
/*
 * two-flop synchroniser for a bundle of pin levels.
 * assumes the inputs are asynchronous to clk and are plain levels.
 */
`timescale 1ns/1ps
module jtap_sync
  import jtap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire jtap_pins_t din,
  output jtap_pins_t dout
);

  jtap_pins_t meta_ff;
  jtap_pins_t sync_ff;
  jtap_pins_t nxt_meta;
  jtap_pins_t nxt_sync;

  // first stage feeds only the second stage
  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  // idle values: clock low, mode high, reset asserted, strap high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0, sel: 1'b1};
      sync_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0, sel: 1'b1};
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;

endmodule

//--- jtap_probe.sv
/* probe model: walks the tap and moves serial bits, lsb first.
   assumes the port samples its pins with a much faster clock. */
`timescale 1ns/1ps
module jtap_probe
  import jtap_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  output logic sel,
  input wire logic tdo
);
  // test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
    sel = 1'b1;
  end

  // low 120 ns, high 80 ns: the late output lands well before the rise
  task automatic pulse(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #120 tck = 1'b1;
    q = tdo;
    #80 tck = 1'b0;
  endtask

  // strap is set before the release, which is where it is taken
  task automatic test_reset(input logic s);
    sel = s;
    trst_n = 1'b0;
    #300 trst_n = 1'b1;
    #300;
  endtask

  // from idle to shift, n bits, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    pulse(1'b1, 1'b0, q);
    if (ir) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask
endmodule

//--- jtag_test_access_port_test.sv
/* self-checking bench for the test access port.
   assumes the package, the port and the probe model are compiled first. */
`timescale 1ns/1ps
module jtag_test_access_port_test;
  import jtap_pkg::*;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic SINGLE_WIRE_EN = 1'b0;
  logic tck, tms, tdi, trst_n, sel, q, tdo_w;
  logic tdo, tdo_oe, ret_clk, ret_clk_oe, dbg_sel;
  jtap_ctl_t ctl;
  int n_fail = 0;
  int check_count = 0;
  int n_strobe = 0;
  int n_tck = 0;
  int n_ret_clk = 0;
  int seed = 97917;
  logic tdo_q = 1'b0;
  logic ret_clk_q = 1'b0;
  logic [31:0] got;
  // model: control words the debugger-facing controller must deliver, oldest first
  logic [7:0] ctl_q [$];
  logic [7:0] pat;
  logic [3:0] byp [2] = '{4'h5, 4'hf};

  always #12.5 MCLK = ~MCLK;

  // a released output reads as the inverse, never as a stale value
  assign tdo_w = tdo_oe ? tdo : ~tdo;

  jtap_probe jtap_probe_i (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .sel(sel), .tdo(tdo_w));
  jtap_port jtap_port_i (.MCLK(MCLK), .RESETN(RESETN), .TEST_RESET_N(trst_n),
    .TEST_CLK(tck), .TEST_MODE(tms), .TEST_DIN(tdi), .CTRL_SELECT(sel),
    .SINGLE_WIRE_EN(SINGLE_WIRE_EN), .TEST_DOUT(tdo), .TEST_DOUT_OE(tdo_oe),
    .RETURN_TEST_CLOCK(ret_clk), .RETURN_TEST_CLOCK_OE(ret_clk_oe),
    .DEBUG_SELECTED(dbg_sel), .CTRL_WRITE(ctl));

  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] t=%0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask

  task automatic mclk(input int n);
    repeat (n) @(posedge MCLK);
    #2;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // output may move only in the low phase; count strobes and echoes
  always @(posedge MCLK) begin
    if (tdo !== tdo_q && tck === 1'b1) fail("serial out moved, clock high");
    if (SINGLE_WIRE_EN && ret_clk !== 1'b0) fail("echo in single-wire use");
    if (ctl.strobe === 1'b1) begin
      n_strobe++;
      check_count++;
      if (ctl_q.size() == 0 || ctl.data !== ctl_q[0]) fail("strobe not in model");
      if (ctl_q.size() != 0) void'(ctl_q.pop_front());
    end
    if (ret_clk === 1'b1 && ret_clk_q === 1'b0) n_ret_clk++;
    tdo_q = tdo;
    ret_clk_q = ret_clk;
  end

  always @(posedge tck) if (!SINGLE_WIRE_EN) n_tck++;

  initial begin
    mclk(16);
    RESETN = 1'b1;
    mclk(4);
    chk1(dbg_sel, 1'b1, "strap default");
    chk1(tdo_oe, 1'b0, "oe after reset");
    jtap_probe_i.test_reset(1'b1);
    chk1(dbg_sel, 1'b1, "debugger chosen");
    jtap_probe_i.pulse(1'b0, 1'b0, q);
    jtap_probe_i.scan(1'b0, 32, $random(seed), got);
    chk(got, JTAP_IDCODE_VAL, "id after test reset");
    jtap_probe_i.scan(1'b1, 4, {28'h0, JTAP_IR_CTRL}, got);
    chk(got, 32'h1, "ir capture");
    pat = $random(seed);
    ctl_q.push_back(pat);
    jtap_probe_i.scan(1'b0, 8, {24'h0, pat}, got);
    mclk(6);
    chk(n_strobe, 1, "one control update");
    chk({24'h0, ctl.data}, {24'h0, pat}, "control data");
    // unknown code 5 and the bypass code behave as bypass: one stage of delay
    foreach (byp[k]) begin
      jtap_probe_i.scan(1'b1, 4, {28'h0, byp[k]}, got);
      pat = $random(seed);
      jtap_probe_i.scan(1'b0, 8, {24'h0, pat}, got);
      chk(got, {24'h0, pat[6:0], 1'b0}, "bypass delay");
    end
    repeat (JTAP_TLR_ONES) jtap_probe_i.pulse(1'b1, 1'b0, q);
    jtap_probe_i.pulse(1'b0, 1'b0, q);
    jtap_probe_i.scan(1'b0, 32, 32'h0, got);
    chk(got, JTAP_IDCODE_VAL, "id after five ones");
    // id scan paused after four bits; the pause and exit arcs must hold the register
    jtap_probe_i.pulse(1'b1, 1'b0, q);
    repeat (2) jtap_probe_i.pulse(1'b0, 1'b0, q);
    for (int i = 0; i < 32; i++) begin
      jtap_probe_i.pulse(i == 3 || i == 31, 1'b0, got[i]);
      if (i == 3) begin
        jtap_probe_i.pulse(1'b0, 1'b0, q);
        jtap_probe_i.pulse(1'b0, 1'b0, q);
        jtap_probe_i.pulse(1'b1, 1'b0, q);
        jtap_probe_i.pulse(1'b0, 1'b0, q);
      end
    end
    jtap_probe_i.pulse(1'b1, 1'b0, q);
    jtap_probe_i.pulse(1'b0, 1'b0, q);
    chk(got, JTAP_IDCODE_VAL, "id across pause");
    // test reset in mid-shift, strap low this time
    jtap_probe_i.pulse(1'b1, 1'b0, q);
    repeat (3) jtap_probe_i.pulse(1'b0, 1'b1, q);
    mclk(6);
    chk1(tdo_oe, 1'b1, "oe in shift");
    jtap_probe_i.test_reset(1'b0);
    chk1(tdo_oe, 1'b0, "oe after test reset");
    chk1(dbg_sel, 1'b0, "factory choice");
    jtap_probe_i.pulse(1'b0, 1'b0, q);
    jtap_probe_i.scan(1'b1, 4, {28'h0, JTAP_IR_CTRL}, got);
    jtap_probe_i.scan(1'b0, 8, {24'h0, ~ctl.data}, got);
    mclk(6);
    chk(n_strobe, 1, "update refused");
    jtap_probe_i.test_reset(1'b1);
    chk1(dbg_sel, 1'b1, "debugger again");
    mclk(4);
    chk(n_ret_clk, n_tck, "echo count");
    chk1(ret_clk_oe, 1'b1, "echo pin owned");
    SINGLE_WIRE_EN = 1'b1;
    mclk(3);
    chk1(ret_clk_oe, 1'b0, "pin given away");
    repeat (4) jtap_probe_i.pulse(1'b0, 1'b0, q);
    SINGLE_WIRE_EN = 1'b0;
    mclk(3);
    chk1(ret_clk_oe, 1'b1, "pin taken back");
    chk(ctl_q.size(), 0, "model writes left over");
    give_verdict();
  end

  // the run needs about 47 us; allow about ten times that
  initial begin
    #500000;
    fail("watchdog expired");
    give_verdict();
  end
endmodule
